// File: pkg/cbs_pkg.sv
// constants, register layout and types of the battery charge supervisor
package cbs_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned BAUD_RATE     = 9600;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_RATE;
  localparam int unsigned TICKS_PER_SEC = 10;
  localparam int unsigned INIT_S        = 4;
  localparam int unsigned TRICKLE_S     = 3600;
  localparam int unsigned DT_WINDOW_S   = 60;
  localparam int unsigned ZDV_TIMEOUT_S = 255;
  localparam int unsigned ZDV_DROP_MV   = 47;
  localparam int unsigned HIRES_UV      = 5850;
  localparam int unsigned ZDV_DROP_CNT  = ZDV_DROP_MV * 1000 / HIRES_UV;
  localparam logic [15:0] HIRES_PER_LORES = 16'h000a;
  localparam int unsigned PWM_PRESC     = 16;
  localparam logic [7:0]  PWM_STEPS     = 8'h64;
  localparam logic [7:0]  HOST_AMP_CAP  = 8'h6e;
  localparam logic [7:0]  AMP_MARGIN    = 8'h0a;

  localparam logic [7:0]  TERM_ABS_VOLT = 8'h70;
  localparam logic [7:0]  TERM_T_SLOPE  = 8'h60;
  localparam logic [7:0]  TERM_DELTA_V  = 8'h50;
  localparam logic [7:0]  SETUP_PACK_ONE = 8'h60;
  localparam logic [7:0]  SETUP_PACK_TWO = 8'ha0;

  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_CFG_TERM  = 8'h08;
  localparam logic [7:0]  OFS_CFG_TEMP  = 8'h0c;
  localparam logic [7:0]  OFS_CFG_VOLT  = 8'h10;
  localparam logic [7:0]  OFS_CFG_AMP   = 8'h14;
  localparam logic [7:0]  OFS_CFG_TIME  = 8'h18;
  localparam logic [7:0]  OFS_MEAS      = 8'h1c;
  localparam logic [7:0]  OFS_SECONDS   = 8'h20;
  localparam logic [7:0]  CTRL_RST      = 8'h00;

  typedef struct packed {
    logic [7:0] pack_two_setup_code;
    logic [7:0] pack_one_setup_code;
    logic [7:0] pack_two_termination_select;
    logic [7:0] pack_one_termination_select;
  } cbs_term_t;

  typedef struct packed {
    logic [7:0] trickle_temp_ceiling;
    logic [7:0] trickle_temp_floor;
    logic [7:0] rapid_temp_ceiling;
    logic [7:0] rapid_temp_floor;
  } cbs_temp_t;

  typedef struct packed {
    logic [7:0] discharge_volt_floor;
    logic [7:0] absolute_volt_stop_level;
    logic [7:0] rapid_volt_floor;
    logic [7:0] rapid_volt_ceiling;
  } cbs_volt_t;

  typedef struct packed {
    logic [7:0] voltage_slope_stop_level;
    logic [7:0] pwm_duty_ceiling;
    logic [7:0] trickle_current_ceiling;
    logic [7:0] rapid_current_ceiling;
  } cbs_amp_t;

  typedef struct packed {
    logic [7:0]  unused;
    logic [7:0]  temp_slope_stop_level;
    logic [15:0] rapid_charge_time_limit;
  } cbs_time_t;

  typedef struct packed {
    logic [15:0] volt;
    logic [7:0]  amp;
    logic [7:0]  temp;
  } cbs_sample_t;

  localparam cbs_term_t TERM_RST = '{8'ha0, 8'h60, 8'h50, 8'h50};
  localparam cbs_temp_t TEMP_RST = '{8'h5a, 8'h00, 8'h5a, 8'h00};
  localparam cbs_volt_t VOLT_RST = '{8'h44, 8'h70, 8'h3d, 8'h70};
  localparam cbs_amp_t  AMP_RST  = '{8'h9c, 8'h55, 8'h01, 8'h6e};
  localparam cbs_time_t TIME_RST = '{8'h00, 8'h02, 16'h0e10};

  typedef enum logic [2:0] {SQ_IDLE, SQ_DIS1, SQ_DIS2, SQ_FAST1, SQ_FAST2, SQ_TRK} cbs_seq_t;
  typedef enum logic [1:0] {SN_IDLE, SN_LOW, SN_WAIT, SN_EVAL} cbs_sense_t;

endpackage : cbs_pkg

// File: verilog/cbs_charge_supervisor.sv
// two-pack charge supervisor with termination tests, fail-safe limits and ahb-lite registers
//
// Contract
// - duty cycle never exceeds the duty ceiling, default 85 percent, both modes
// - zero delta-v selected: end fast charge after 255 s without voltage change
// - zero delta-v selected: end fast charge when voltage drop exceeds 47 mV
// - host mode caps fast charge current at 1100 mA; cap is build option
// - host mode takes windowed voltage at 5.85 mV/bit into 16 bits
// - high-resolution voltage becomes 58.5 mV/bit before the limit, absolute and discharge decisions; delta-v and flat time use 5.85 mV/bit
// - fixed mode samples voltage directly as 8-bit unsigned value
// - fixed mode debounces both pushbuttons on the 0.1 s tick
// - both buttons pressed: charge both packs in turn via sequencer
// - fixed mode charges only; discharge states are skipped
// - host mode: serial commands are received, parsed, executed and echoed
// - host mode parameters writable; fixed mode parameters constant
// - termination select 0x70 absolute, 0x60 temperature slope, 0x50 delta-v
// - setup codes 0x60 pack one, 0xa0 pack two: charge once
// - temperature limits signed 0.5 C/bit, defaults 0x00 and 0x5a
// - voltage limits 58.5 mV/bit: defaults 0x70 high/abs, 0x3d low, 0x44 floor
// - fast charge ends when seconds counter reaches time limit 0x0e10
// - current limits 10 mA/bit: defaults 0x6e fast, 0x01 trickle
// - delta-v threshold 5.85 mV/bit, default 0x9c
// - temperature slope threshold 0.5 C/min, default 0x02
// - each second wait pwm low, hold it, sample, then release
// - any fail-safe limit after initialisation stops charging on all packs
// - stages run discharge, fast, trickle, repeat, idle; unselected skipped
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cbs_charge_supervisor
  import cbs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
  parameter int unsigned BIT_CYCLES_P  = BIT_CYCLES,
  parameter int unsigned TRICKLE_S_P   = TRICKLE_S,
  parameter bit          HOST_CAP_EN   = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        fixed_profile_pin,
  input  wire logic        pack_one_button,
  input  wire logic        pack_two_button,
  input  wire logic        uart_rx,
  output logic             uart_tx,
  output logic             sense_req,
  output logic             sense_pack,
  input  wire logic        sense_valid,
  input  wire cbs_sample_t sense_data,
  output logic             pwm_out,
  output logic      [1:0]  charge_pack_sel,
  output logic      [1:0]  discharge_en
);

  function automatic logic [7:0] to_lores(input logic [15:0] v);
    logic [15:0] q;
    q = v / HIRES_PER_LORES;
    return (q > 16'h00ff) ? 8'hff : q[7:0];
  endfunction : to_lores

  function automatic cbs_seq_t seq_after(input cbs_seq_t cur, input logic [6:0] sel,
                                         input logic fixed, input logic [1:0] ok);
    logic [4:0] en;
    cbs_seq_t   res;
    en  = {sel[5] | sel[4], sel[3] & ok[1], sel[2] & ok[0], sel[1] & ~fixed, sel[0] & ~fixed};
    res = SQ_IDLE;
    for (int i = 5; i >= 1; i--) begin
      if (en[i-1] && i > int'(cur)) res = cbs_seq_t'(i);
    end
    if (res == SQ_IDLE && sel[6]) begin
      for (int i = 5; i >= 1; i--) begin
        if (en[i-1]) res = cbs_seq_t'(i);
      end
    end
    return res;
  endfunction : seq_after

  // three-stage synchronisers; a level counts once stages two and three agree
  logic [2:0]  fix_q_r, b1_q_r, b2_q_r, rx_q_r;
  logic        fixed_r, b1_r, b2_r, rx_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fix_q_r <= 3'h0;
      b1_q_r  <= 3'h0;
      b2_q_r  <= 3'h0;
      rx_q_r  <= 3'h7;
      fixed_r <= 1'b0;
      b1_r    <= 1'b0;
      b2_r    <= 1'b0;
      rx_r    <= 1'b1;
    end else begin
      fix_q_r <= {fix_q_r[1:0], fixed_profile_pin};
      b1_q_r  <= {b1_q_r[1:0], pack_one_button};
      b2_q_r  <= {b2_q_r[1:0], pack_two_button};
      rx_q_r  <= {rx_q_r[1:0], uart_rx};
      if (fix_q_r[1] == fix_q_r[2]) fixed_r <= fix_q_r[2];
      if (b1_q_r[1] == b1_q_r[2]) b1_r <= b1_q_r[2];
      if (b2_q_r[1] == b2_q_r[2]) b2_r <= b2_q_r[2];
      if (rx_q_r[1] == rx_q_r[2]) rx_r <= rx_q_r[2];
    end
  end

  // time base
  logic [31:0] tick_cnt_r;
  logic        tick_r, sec_r;
  logic [3:0]  tenth_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
      tenth_r    <= 4'h0;
      sec_r      <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == 32'(TICK_CYCLES_P - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES_P - 1)) ? 32'h0 : tick_cnt_r + 32'h1;
      sec_r  <= tick_r && (tenth_r == 4'(TICKS_PER_SEC - 1));
      if (tick_r) tenth_r <= (tenth_r == 4'(TICKS_PER_SEC - 1)) ? 4'h0 : tenth_r + 4'h1;
    end
  end

  // effective parameters: writable words in host mode, constants in fixed mode
  logic [31:0] cfg_r [5];
  cbs_term_t   term;
  cbs_temp_t   tlim;
  cbs_volt_t   vlim;
  cbs_amp_t    alim;
  cbs_time_t   tmlim;
  assign term  = fixed_r ? TERM_RST : cbs_term_t'(cfg_r[0]);
  assign tlim  = fixed_r ? TEMP_RST : cbs_temp_t'(cfg_r[1]);
  assign vlim  = fixed_r ? VOLT_RST : cbs_volt_t'(cfg_r[2]);
  assign alim  = fixed_r ? AMP_RST  : cbs_amp_t'(cfg_r[3]);
  assign tmlim = fixed_r ? TIME_RST : cbs_time_t'(cfg_r[4]);

  // ahb-lite slave, zero wait states, always okay
  logic        ap_wr_r;
  logic [7:0]  ap_addr_r;
  logic [31:0] rd_word;
  logic        ctrl_wr;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        ap_wr_r   <= hsel & htrans[1] & hwrite;
        ap_addr_r <= haddr[7:0];
        if (hsel & htrans[1] & ~hwrite) hrdata <= (haddr[31:8] == 24'h0) ? rd_word : 32'h0;
      end
    end
  end
  assign ctrl_wr = ap_wr_r && ap_addr_r == OFS_CTRL;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_r[0] <= TERM_RST;
      cfg_r[1] <= TEMP_RST;
      cfg_r[2] <= VOLT_RST;
      cfg_r[3] <= AMP_RST;
      cfg_r[4] <= TIME_RST;
    end else if (ap_wr_r && !fixed_r) begin
      for (int i = 0; i < 5; i++) begin
        if (ap_addr_r == OFS_CFG_TERM + 8'(4 * i)) cfg_r[i] <= hwdata;
      end
    end
  end

  // uart receiver and echo transmitter, 8n1
  logic [31:0] rx_cnt_r, tx_cnt_r;
  logic [3:0]  rx_bit_r, tx_bit_r;
  logic [7:0]  rx_sh_r;
  logic [9:0]  tx_sh_r;
  logic        rx_busy_r, rx_done_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_cnt_r  <= 32'h0;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
      rx_busy_r <= 1'b0;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_r) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r  <= 32'(BIT_CYCLES_P / 2);
          rx_bit_r  <= 4'h0;
        end
      end else if (rx_cnt_r != 32'h0) begin
        rx_cnt_r <= rx_cnt_r - 32'h1;
      end else begin
        rx_cnt_r <= 32'(BIT_CYCLES_P - 1);
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && rx_r) rx_busy_r <= 1'b0;
        if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8) rx_sh_r <= {rx_r, rx_sh_r[7:1]};
        if (rx_bit_r == 4'h9) begin
          rx_busy_r <= 1'b0;
          rx_done_r <= rx_r; // framing error drops the byte
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_sh_r  <= 10'h3ff;
      tx_cnt_r <= 32'h0;
      tx_bit_r <= 4'h0;
      uart_tx  <= 1'b1;
    end else if (rx_done_r && !fixed_r) begin
      tx_sh_r  <= {1'b1, rx_sh_r, 1'b0};
      tx_bit_r <= 4'ha;
      tx_cnt_r <= 32'h0;
    end else if (tx_bit_r != 4'h0) begin
      if (tx_cnt_r == 32'h0) begin
        uart_tx  <= tx_sh_r[0];
        tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
        tx_bit_r <= tx_bit_r - 4'h1;
        tx_cnt_r <= 32'(BIT_CYCLES_P - 1);
      end else begin
        tx_cnt_r <= tx_cnt_r - 32'h1;
      end
    end else if (tx_cnt_r != 32'h0) begin
      tx_cnt_r <= tx_cnt_r - 32'h1;
    end else begin
      uart_tx <= 1'b1;
    end
  end

  // command sources: ctrl register, serial byte, or pushbuttons
  logic [1:0]  btn_prev_r, btn_deb_r, btn_pend_r;
  logic [6:0]  sel_r;
  logic        zdv_en_r, start_r, stop_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      btn_prev_r <= 2'b00;
      btn_deb_r  <= 2'b00;
      btn_pend_r <= 2'b00;
    end else if (tick_r) begin
      btn_prev_r <= {b2_r, b1_r};
      btn_deb_r  <= {b2_r, b1_r} & btn_prev_r;
      if (btn_deb_r != 2'b00) btn_pend_r <= btn_pend_r | btn_deb_r;
      else btn_pend_r <= 2'b00;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_r    <= CTRL_RST[6:0];
      zdv_en_r <= CTRL_RST[7];
      start_r  <= 1'b0;
      stop_r   <= 1'b0;
    end else begin
      start_r <= 1'b0;
      stop_r  <= 1'b0;
      if (fixed_r) begin
        // start on release so that a two-button press is seen whole
        if (tick_r && btn_deb_r == 2'b00 && btn_pend_r != 2'b00) begin
          sel_r   <= {1'b0, btn_pend_r, btn_pend_r, 2'b00};
          start_r <= 1'b1;
        end
      end else if (ctrl_wr || rx_done_r) begin
        sel_r   <= ctrl_wr ? hwdata[6:0] : rx_sh_r[6:0];
        if (ctrl_wr) zdv_en_r <= hwdata[7];
        start_r <= ctrl_wr ? (hwdata[6:0] != 7'h0) : (rx_sh_r[6:0] != 7'h0);
        stop_r  <= ctrl_wr ? (hwdata[6:0] == 7'h0) : (rx_sh_r[6:0] == 7'h0);
      end
    end
  end

  // once a second: wait for pwm low, hold it, sample, release
  cbs_sense_t  sn_r;
  cbs_sample_t samp_r;
  logic        pwm_hold_r;
  logic        trk_pick_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sn_r       <= SN_IDLE;
      samp_r     <= '0;
      pwm_hold_r <= 1'b0;
      sense_req  <= 1'b0;
    end else begin
      sense_req <= 1'b0;
      case (sn_r)
        SN_IDLE: if (sec_r) sn_r <= SN_LOW;
        SN_LOW: begin
          if (!pwm_out) begin
            pwm_hold_r <= 1'b1;
            sense_req  <= 1'b1;
            sn_r       <= SN_WAIT;
          end
        end
        SN_WAIT: begin
          if (sense_valid) begin
            samp_r <= sense_data;
            sn_r   <= SN_EVAL;
          end
        end
        SN_EVAL: begin
          pwm_hold_r <= 1'b0;
          sn_r       <= SN_IDLE;
        end
        default: sn_r <= SN_IDLE;
      endcase
    end
  end

  // measurement views shared by both modes
  cbs_seq_t    seq_r;
  logic        eval;
  logic [15:0] v_hi;
  logic [7:0]  v_lo;
  logic        pack_two;
  assign eval     = (sn_r == SN_EVAL);
  assign pack_two = (seq_r == SQ_DIS2) | (seq_r == SQ_FAST2) |
                    (seq_r == SQ_TRK && trk_pick_r);
  assign v_hi = fixed_r ? 16'({8'h00, samp_r.volt[7:0]} * HIRES_PER_LORES)
                        : samp_r.volt;
  assign v_lo = fixed_r ? samp_r.volt[7:0] : to_lores(samp_r.volt);

  // termination and fail-safe decisions
  logic [15:0] stage_s_r, peak_r, last_v_r;
  logic [7:0]  flat_s_r;
  logic [5:0]  dt_s_r;
  logic [7:0]  t_ref_r;
  logic        dt_hit_r;
  logic        fast, trk, init_done, term_hit, fail, done, adv;
  logic [7:0]  tsel, drop8;
  logic [15:0] drop;
  assign fast      = (seq_r == SQ_FAST1) || (seq_r == SQ_FAST2);
  assign trk       = (seq_r == SQ_TRK);
  assign init_done = stage_s_r >= 16'(INIT_S);
  assign tsel      = pack_two ? term.pack_two_termination_select
                              : term.pack_one_termination_select;
  assign drop      = (peak_r > v_hi) ? peak_r - v_hi : 16'h0;
  assign drop8     = (drop > 16'h00ff) ? 8'hff : drop[7:0];

  always_comb begin
    term_hit = 1'b0;
    case (tsel)
      TERM_ABS_VOLT: term_hit = v_lo >= vlim.absolute_volt_stop_level;
      TERM_T_SLOPE:  term_hit = dt_hit_r;
      TERM_DELTA_V: begin
        term_hit = drop8 > alim.voltage_slope_stop_level;
        if (zdv_en_r && (drop > 16'(ZDV_DROP_CNT) || flat_s_r >= 8'(ZDV_TIMEOUT_S)))
          term_hit = 1'b1;
      end
      default: term_hit = 1'b0;
    endcase
    if (stage_s_r >= tmlim.rapid_charge_time_limit) term_hit = 1'b1;
  end

  always_comb begin
    fail = 1'b0;
    if (fast) begin
      fail = $signed(samp_r.temp) < $signed(tlim.rapid_temp_floor) ||
             $signed(samp_r.temp) > $signed(tlim.rapid_temp_ceiling) ||
             v_lo > vlim.rapid_volt_ceiling || v_lo < vlim.rapid_volt_floor ||
             samp_r.amp > 8'(alim.rapid_current_ceiling + AMP_MARGIN);
    end else if (trk) begin
      fail = $signed(samp_r.temp) < $signed(tlim.trickle_temp_floor) ||
             $signed(samp_r.temp) > $signed(tlim.trickle_temp_ceiling) ||
             samp_r.amp > 8'(alim.trickle_current_ceiling + AMP_MARGIN);
    end
    fail = fail && init_done;
  end

  always_comb begin
    case (seq_r)
      SQ_DIS1, SQ_DIS2:   done = v_lo < vlim.discharge_volt_floor;
      SQ_FAST1, SQ_FAST2: done = init_done && term_hit;
      SQ_TRK:             done = stage_s_r >= 16'(TRICKLE_S_P);
      default:            done = 1'b0;
    endcase
  end
  assign adv = start_r || (eval && (fail || done));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage_s_r <= 16'h0;
      peak_r    <= 16'h0;
      last_v_r  <= 16'h0;
      flat_s_r  <= 8'h00;
      dt_s_r    <= 6'h00;
      t_ref_r   <= 8'h00;
      dt_hit_r  <= 1'b0;
    end else if (adv) begin
      stage_s_r <= 16'h0;
      peak_r    <= 16'h0;
      flat_s_r  <= 8'h00;
      dt_s_r    <= 6'h00;
      dt_hit_r  <= 1'b0;
    end else if (eval) begin
      if (stage_s_r != 16'hffff) stage_s_r <= stage_s_r + 16'h1;
      if (v_hi > peak_r) peak_r <= v_hi;
      last_v_r <= v_hi;
      if (v_hi != last_v_r) flat_s_r <= 8'h00;
      else if (flat_s_r != 8'hff) flat_s_r <= flat_s_r + 8'h1;
      // slope is judged over whole minutes against the reading a minute ago
      if (dt_s_r == 6'(DT_WINDOW_S - 1) || stage_s_r == 16'h0) begin
        dt_s_r  <= 6'h00;
        t_ref_r <= samp_r.temp;
        dt_hit_r <= stage_s_r != 16'h0 &&
                    $signed(samp_r.temp) - $signed(t_ref_r) >
                    $signed({1'b0, tmlim.temp_slope_stop_level});
      end else begin
        dt_s_r <= dt_s_r + 6'h1;
      end
    end
  end

  // stage sequencer
  logic [1:0] setup_ok;
  logic       fault_r;
  assign setup_ok = {term.pack_two_setup_code == SETUP_PACK_TWO,
                     term.pack_one_setup_code == SETUP_PACK_ONE};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seq_r      <= SQ_IDLE;
      fault_r    <= 1'b0;
      trk_pick_r <= 1'b0;
    end else if (stop_r) begin
      seq_r <= SQ_IDLE;
    end else if (start_r) begin
      seq_r      <= seq_after(SQ_IDLE, sel_r, fixed_r, setup_ok);
      fault_r    <= 1'b0;
      trk_pick_r <= ~sel_r[4];
    end else if (eval) begin
      if (fail) begin
        seq_r   <= SQ_IDLE;
        fault_r <= 1'b1;
      end else if (done) begin
        seq_r      <= seq_after(seq_r, sel_r, fixed_r, setup_ok);
        trk_pick_r <= ~sel_r[4];
      end else if (trk && sel_r[4] && sel_r[5]) begin
        trk_pick_r <= ~trk_pick_r; // both packs share trickle in turn
      end
    end
  end

  // duty regulation and pwm generator
  logic [7:0] duty_r, ceil, target;
  logic [7:0] pct_r;
  logic [4:0] presc_r;
  assign ceil   = (alim.pwm_duty_ceiling > PWM_STEPS) ? PWM_STEPS : alim.pwm_duty_ceiling;
  assign target = trk ? alim.trickle_current_ceiling :
                  (HOST_CAP_EN && !fixed_r && alim.rapid_current_ceiling > HOST_AMP_CAP)
                  ? HOST_AMP_CAP : alim.rapid_current_ceiling;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      duty_r <= 8'h00;
    end else if (seq_r == SQ_IDLE || adv) begin
      duty_r <= 8'h00;
    end else if (seq_r == SQ_DIS1 || seq_r == SQ_DIS2) begin
      duty_r <= ceil;
    end else if (eval && init_done) begin
      if (samp_r.amp < target && duty_r < ceil) duty_r <= duty_r + 8'h1;
      else if (samp_r.amp > target && duty_r != 8'h00) duty_r <= duty_r - 8'h1;
      if (duty_r > ceil) duty_r <= ceil;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_r         <= 5'h00;
      pct_r           <= 8'h00;
      pwm_out         <= 1'b0;
      sense_pack      <= 1'b0;
      charge_pack_sel <= 2'b00;
      discharge_en    <= 2'b00;
    end else begin
      presc_r <= (presc_r == 5'(PWM_PRESC - 1)) ? 5'h00 : presc_r + 5'h1;
      if (presc_r == 5'(PWM_PRESC - 1)) pct_r <= (pct_r == PWM_STEPS - 8'h1) ? 8'h00 : pct_r + 8'h1;
      // the hold flop lands one edge late, so keep a low seen in the SN_LOW state
      pwm_out <= !(pwm_hold_r || (sn_r == SN_LOW && !pwm_out)) && pct_r < duty_r &&
                 pct_r < ceil;
      sense_pack      <= pack_two;
      charge_pack_sel <= (fast || trk) ? {pack_two, ~pack_two} : 2'b00;
      discharge_en    <= {seq_r == SQ_DIS2, seq_r == SQ_DIS1};
    end
  end

  always_comb begin
    case (haddr[7:0])
      OFS_CTRL:     rd_word = {24'h0, zdv_en_r, sel_r};
      OFS_STATUS:   rd_word = {20'h0, trk_pick_r, fixed_r, fault_r, pwm_hold_r,
                               1'b0, seq_r, sn_r, 2'b00};
      OFS_CFG_TERM: rd_word = term;
      OFS_CFG_TEMP: rd_word = tlim;
      OFS_CFG_VOLT: rd_word = vlim;
      OFS_CFG_AMP:  rd_word = alim;
      OFS_CFG_TIME: rd_word = tmlim;
      OFS_MEAS:     rd_word = {duty_r, v_lo, samp_r.amp, samp_r.temp};
      OFS_SECONDS:  rd_word = {16'h0, stage_s_r};
      default:      rd_word = 32'h0;
    endcase
  end

endmodule : cbs_charge_supervisor
`default_nettype wire

// File: sim/cbs_properties.sv
// port assertions for the charge supervisor
`timescale 1ns/100ps
`default_nettype none
module cbs_properties (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       hreadyout,
  input wire logic       sense_req,
  input wire logic       sense_valid,
  input wire logic       pwm_out,
  input wire logic [1:0] charge_pack_sel,
  input wire logic [1:0] discharge_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [11:0] hi_r;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) hi_r <= 12'h000;
    else hi_r <= pwm_out ? hi_r + 12'h001 : 12'h000;
  sequence s_ask;
    sense_req && !pwm_out;
  endsequence
  property p_ok; hreadyout; endproperty
  a_ok: assert property (p_ok) else $error("slave not ready");
  property p_pulse; s_ask |=> !sense_req; endproperty
  a_pulse: assert property (p_pulse) else $error("long request");
  property p_low; sense_req |-> !pwm_out; endproperty
  a_low: assert property (p_low) else $error("request with pwm high");
  property p_hold; s_ask |=> !pwm_out until_with sense_valid; endproperty
  a_hold: assert property (p_hold) else $error("pwm not held");
  property p_duty; hi_r <= 12'h550; endproperty
  a_duty: assert property (p_duty) else $error("duty above ceiling");
  property p_one_c; $onehot0(charge_pack_sel); endproperty
  a_one_c: assert property (p_one_c) else $error("two packs charging");
  property p_one_d; $onehot0(discharge_en); endproperty
  a_one_d: assert property (p_one_d) else $error("two discharges");
  property p_excl; !(|charge_pack_sel && |discharge_en); endproperty
  a_excl: assert property (p_excl) else $error("two stages at once");
endmodule : cbs_properties
`default_nettype wire

// File: sim/cbs_sense_model.sv
// sense converter model: one sample per request after a set delay
`timescale 1ns/100ps
`default_nettype none
module cbs_sense_model import cbs_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        sense_req,
  input  wire logic [3:0]  dly,
  input  wire cbs_sample_t smp,
  output logic             sense_valid,
  output cbs_sample_t      sense_data
);
  always @(posedge core_clk) begin
    sense_valid <= '0;
    sense_data <= ~smp;  // no stale sample outside an answer
    if (sense_req) begin
      repeat (dly) @(posedge core_clk);
      sense_valid <= '1;
      sense_data <= smp;
      @(posedge core_clk);
      sense_valid <= '0;
      sense_data <= ~smp;
    end
  end
endmodule : cbs_sense_model
`default_nettype wire

// File: sim/battery_charge_supervisor_test.sv
// self-checking bench for the charge supervisor
`timescale 1ns/100ps
`default_nettype none
module battery_charge_supervisor_test;
  import cbs_pkg::*;
  logic core_clk = '0, rst = '1, hsel = '0, hwrite = '0, fixed_profile_pin = '0;
  logic pack_one_button = '0, pack_two_button = '0, uart_rx = '1;
  logic hreadyout, hresp, uart_tx, sense_req, sense_pack, sense_valid, pwm_out;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0]  htrans = '0, charge_pack_sel, discharge_en;
  logic [7:0]  e, l, s;
  logic [3:0]  dly = 4'h1;
  cbs_sample_t sense_data, smp = '0;
  int fail_count = 0, n_compared = 0, seed = 22185, i;
  logic [31:0] mdl [2:6] = '{32'ha0605050, 32'h5a005a00, 32'h44703d70, 32'h9c55016e, 32'h00020e10};
  always #12.5 core_clk = ~core_clk;
  cbs_charge_supervisor #(.TICK_CYCLES_P(40), .BIT_CYCLES_P(16), .TRICKLE_S_P(5)) uut (
    .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .fixed_profile_pin, .pack_one_button, .pack_two_button,
    .uart_rx, .uart_tx, .sense_req, .sense_pack, .sense_valid, .sense_data, .pwm_out,
    .charge_pack_sel, .discharge_en);
  cbs_sense_model u_snm (.core_clk, .sense_req, .dly, .smp, .sense_valid, .sense_data);
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic guard(input int k, lim);
    if (k >= lim) begin
      fail_count++;
      end_sim();
    end
  endtask : guard
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    hsel <= '1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== '1 && k++ < 50);
    hsel <= '0; htrans <= 2'h0; hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== '1 && k++ < 50);
    guard(k, 50);
    r = hrdata;
  endtask : ahb
  task automatic send(input logic [7:0] b);
    logic [9:0] f = {1'b1, b, 1'b0};
    for (int j = 0; j < 10; j++) begin
      uart_rx <= f[j];
      cyc(16);
    end
  endtask : send
  task automatic echo;
    int k = 0;
    while (uart_tx !== '0 && k++ < 600) @(posedge core_clk);
    guard(k, 600);
    cyc(8);
    for (int j = 0; j < 8; j++) begin cyc(16); e[j] = uart_tx; end
    cyc(16); // into the stop bit
  endtask : echo
  initial begin
    l = 8'h40 + 8'($random(seed) & 31);
    smp <= '{16'(l) * 16'h000a, 8'h20, 8'h30};  // windowed reading at a tenth of a step
    cyc(3);
    rst <= '0;
    for (int a = 2; a <= 6; a++) begin ahb('0, 8'(a * 4), '0); chk(r, mdl[a]); end
    ahb('0, 8'h40, '0);
    chk(r, 32'h0);
    mdl[6][23:16] = 8'($random(seed));
    ahb('1, OFS_CFG_TIME, mdl[6]);
    ahb('0, OFS_CFG_TIME, '0);
    chk(r, mdl[6]);
    for (int j = 0; j < 2; j++) begin
      s = j ? 8'h00 : 8'($random(seed));
      fork send(s); echo(); join
      chk(e, s);
    end
    dly <= 4'h1 + 4'($random(seed) & 7);
    ahb('1, OFS_CTRL, 32'h04);
    cyc(2400);
    chk(charge_pack_sel, 2'b01);
    ahb('0, OFS_MEAS, '0);
    chk(r[23:0], {l, 8'h20, 8'h30});
    smp.temp <= 8'h5b;  // one step over the ceiling
    for (i = 0; charge_pack_sel !== 2'b00; i++) begin guard(i, 1200); cyc(1); end
    ahb('0, OFS_STATUS, '0);
    chk(r[9], 1'b1);
    smp <= '{16'(l), 8'h20, 8'h30};
    {fixed_profile_pin, pack_one_button, pack_two_button} <= 3'h7;
    cyc(200);
    {pack_one_button, pack_two_button} <= 2'h0;
    for (i = 0; charge_pack_sel === 2'b00; i++) begin guard(i, 400); cyc(1); end
    chk({discharge_en, charge_pack_sel}, 4'h1);
    cyc(800);
    ahb('0, OFS_MEAS, '0);
    chk(r[23:16], l);
    end_sim();
  end
endmodule : battery_charge_supervisor_test
bind cbs_charge_supervisor cbs_properties u_prop (.core_clk, .rst, .hreadyout, .sense_req,
  .sense_valid, .pwm_out, .charge_pack_sel, .discharge_en);
`default_nettype wire
